/* core/display_audio_pin_mux.sv */
// Our own choice: the AHB-Lite register port.
module display_audio_pin_mux (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // register bus
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // package strap
  input wire logic i_dram_bonded,
  output logic o_dram_pad_enable,
  output logic o_dram_pad_power,
  // shared video input
  input wire logic [17:0] i_pixel_in,
  input wire logic i_hsync,
  input wire logic i_vsync,
  output logic [9:0] o_capture_pixel,
  output logic [17:0] o_main_display_pixel,
  output logic [17:0] o_secondary_display_pixel,
  // sound generator
  input wire logic i_sound_pwm_out,
  input wire logic i_sound_pwm_out_alt,
  input wire logic i_i2s_sck,
  input wire logic i_i2s_do,
  output logic o_sound_pin_clk,
  output logic o_sound_pin_data,
  // display sources
  input wire logic [15:0] i_display_rgb,
  input wire logic [15:0] i_timing_rgb,
  input wire logic [12:0] i_timing_diff,
  input wire logic i_panel_clock,
  // port A peripherals, index 0..3 = pads 0,1,8,9
  input wire logic [3:0] i_i2c_out,
  input wire logic [3:0] i_i2c_oe,
  output logic [3:0] o_i2c_in,
  input wire logic [3:0] i_timer_out,
  input wire logic [3:0] i_timer_oe,
  output logic [3:0] o_timer_in,
  output logic [15:0] o_gpio_in,
  // port A pads
  input wire logic [15:0] i_pa_in,
  output logic [15:0] o_pa_out,
  output logic [15:0] o_pa_oe_n,
  // port G bit 11 pad
  input wire logic i_pg11_in,
  output logic o_pg11_out,
  output logic o_pg11_oe_n,
  output logic o_pg11_gpio_in,
  // differential special-function pads, slot 270 + index
  output logic [12:0] o_diff_out,
  output logic [12:0] o_diff_obe
);
  // bus data phase
  logic dp_valid_r, dp_valid_nxt;
  logic dp_write_r, dp_write_nxt;
  logic [31:0] dp_addr_r, dp_addr_nxt;
  // registers
  logic misc_r, misc_nxt;
  logic [31:0] pad_opt_r, pad_opt_nxt;
  logic [31:0] pad_gpio_r, pad_gpio_nxt;
  logic [3:0] pg11_r, pg11_nxt;
  logic sound_r, sound_nxt;
  logic [1:0] timing_r, timing_nxt;
  // strap
  logic dram_bonded_r, dram_bonded_nxt;
  logic strap_done_r, strap_done_nxt;
  // mux
  logic timing_active;
  logic diff_on;
  logic pg11_disp;
  logic conflict;
  logic [15:0] disp_data;
  logic [15:0] pad_conflict;

  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  always_comb begin
    dp_valid_nxt = i_hready ? (i_hsel && i_htrans[1]) : dp_valid_r;
    dp_write_nxt = i_hready ? i_hwrite : dp_write_r;
    dp_addr_nxt = i_hready ? i_haddr : dp_addr_r;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r <= 32'h0000_0000;
    end else begin
      dp_valid_r <= dp_valid_nxt;
      dp_write_r <= dp_write_nxt;
      dp_addr_r <= dp_addr_nxt;
    end
  end

  // writes land in the data phase; unmapped writes are dropped
  always_comb begin
    misc_nxt = misc_r;
    pad_opt_nxt = pad_opt_r;
    pad_gpio_nxt = pad_gpio_r;
    pg11_nxt = pg11_r;
    sound_nxt = sound_r;
    timing_nxt = timing_r;
    if (dp_valid_r && dp_write_r) begin
      case (dp_addr_r)
        pin_mux_pkg::MISC_CONTROL_ADDR: begin
          misc_nxt = i_hwdata[pin_mux_pkg::CAPTURE_SEL_BIT]; // see R03
        end
        pin_mux_pkg::PAD_OPTION_ADDR: begin
          pad_opt_nxt = i_hwdata;
        end
        pin_mux_pkg::PAD_GPIO_ADDR: begin
          pad_gpio_nxt = i_hwdata;
        end
        pin_mux_pkg::PG11_CONTROL_ADDR: begin
          pg11_nxt = i_hwdata[3:0];
        end
        pin_mux_pkg::SOUND_CONTROL_ADDR: begin
          sound_nxt = i_hwdata[pin_mux_pkg::SOUND_PWM_ENABLE_BIT];
        end
        pin_mux_pkg::PANEL_TIMING_ONE_ADDR: begin
          timing_nxt = i_hwdata[1:0];
        end
        default: begin
          misc_nxt = misc_r;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      misc_r <= pin_mux_pkg::MISC_CONTROL_RST[0];
      pad_opt_r <= pin_mux_pkg::PAD_OPTION_RST;
      pad_gpio_r <= pin_mux_pkg::PAD_GPIO_RST;
      pg11_r <= pin_mux_pkg::PG11_CONTROL_RST;
      sound_r <= pin_mux_pkg::SOUND_CONTROL_RST;
      timing_r <= pin_mux_pkg::PANEL_TIMING_ONE_RST;
    end else begin
      misc_r <= misc_nxt;
      pad_opt_r <= pad_opt_nxt;
      pad_gpio_r <= pad_gpio_nxt;
      pg11_r <= pg11_nxt;
      sound_r <= sound_nxt;
      timing_r <= timing_nxt;
    end
  end

  // the strap is caught once, on the first edge after reset release
  always_comb begin
    strap_done_nxt = 1'b1;
    dram_bonded_nxt = strap_done_r ? dram_bonded_r : i_dram_bonded;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_done_r <= 1'b0;
      dram_bonded_r <= 1'b0;
    end else begin
      strap_done_r <= strap_done_nxt;
      dram_bonded_r <= dram_bonded_nxt;
    end
  end

  assign o_dram_pad_enable = dram_bonded_r; // see R01
  assign o_dram_pad_power = dram_bonded_r; // see R01

  always_comb begin
    case (dp_addr_r)
      pin_mux_pkg::MISC_CONTROL_ADDR: o_hrdata = {31'h0000_0000, misc_r};
      pin_mux_pkg::PAD_OPTION_ADDR: o_hrdata = pad_opt_r;
      pin_mux_pkg::PAD_GPIO_ADDR: o_hrdata = pad_gpio_r;
      pin_mux_pkg::PG11_CONTROL_ADDR: o_hrdata = {28'h000_0000, pg11_r};
      pin_mux_pkg::SOUND_CONTROL_ADDR: o_hrdata = {31'h0000_0000, sound_r};
      pin_mux_pkg::PANEL_TIMING_ONE_ADDR: o_hrdata = {30'h0000_0000, timing_r};
      pin_mux_pkg::PAD_STATUS_ADDR: begin
        o_hrdata = {13'h0000, !o_pg11_oe_n, dram_bonded_r, conflict, 3'h0, o_diff_obe};
      end
      default: o_hrdata = 32'h0000_0000;
    endcase
  end

  // video input sharing
  assign o_main_display_pixel = i_pixel_in; // see R02
  assign o_secondary_display_pixel = i_pixel_in; // see R02
  assign o_capture_pixel = misc_r ? i_pixel_in[17:8] : // see R05
                           {i_vsync, i_hsync, i_pixel_in[7:0]}; // see R04

  // sound pins
  assign o_sound_pin_clk = sound_r ? i_sound_pwm_out : i_i2s_sck; // see R06 see R07
  assign o_sound_pin_data = sound_r ? i_sound_pwm_out_alt : i_i2s_do; // see R06 see R07

  // timing path runs while bypass is clear
  assign timing_active = !timing_r[pin_mux_pkg::PANEL_BYPASS_BIT];
  assign diff_on = timing_active && timing_r[pin_mux_pkg::REDUCED_SWING_MODE_BIT]; // see R09
  assign disp_data = timing_active ? i_timing_rgb : i_display_rgb; // see R10

  for (genvar i = 0; i < pin_mux_pkg::PA_PADS; i++) begin : g_pa
    localparam bit HAS = (i == 0) || (i == 1) || (i == 8) || (i == 9);
    localparam int K = (i < 8) ? i : i - 6;
    logic [3:0] alt_o;
    logic [3:0] alt_oe;
    logic [3:0] alt_i;
    if (HAS) begin : g_full
      // see R14 see R16
      assign alt_o = {i_timer_out[K], i_i2c_out[K], disp_data[i], pad_gpio_r[i]};
      assign alt_oe = {i_timer_oe[K], i_i2c_oe[K], 1'b1,
                       pad_gpio_r[pin_mux_pkg::PAD_GPIO_OE_LSB + i]};
      assign o_i2c_in[K] = alt_i[2];
      assign o_timer_in[K] = alt_i[3];
    end else begin : g_short
      // see R15
      assign alt_o = {2'h0, disp_data[i], pad_gpio_r[i]};
      assign alt_oe = {2'h0, 1'b1, pad_gpio_r[pin_mux_pkg::PAD_GPIO_OE_LSB + i]};
    end
    pad_mux_cell #(
      .HAS_ALT(HAS)
    ) u_cell (
      .i_option(pad_opt_r[2*i +: 2]),
      .i_diff_active(diff_on),
      .i_alt_out(alt_o),
      .i_alt_oe(alt_oe),
      .o_alt_in(alt_i),
      .i_pad_in(i_pa_in[i]),
      .o_pad_out(o_pa_out[i]),
      .o_pad_oe_n(o_pa_oe_n[i])
    );
    assign o_gpio_in[i] = alt_i[0];
    // software misuse flag: non-display output while timing path runs
    assign pad_conflict[i] = timing_active && !o_pa_oe_n[i] && // see R11
                             (pad_opt_r[2*i +: 2] != pin_mux_pkg::OPT_DISPLAY);
  end

  // differential slots: 8 port A pairs, then port G / M slots, last is port G bit 11
  for (genvar j = 0; j < pin_mux_pkg::DIFF_SLOTS; j++) begin : g_diff
    if (j < pin_mux_pkg::DIFF_PA_PAIRS) begin : g_pa_pair
      assign o_diff_obe[j] = diff_on && // see R08 see R10
                             (pad_opt_r[4*j +: 2] == pin_mux_pkg::OPT_DISPLAY);
    end else if (j < pin_mux_pkg::DIFF_SLOTS - 1) begin : g_other
      assign o_diff_obe[j] = diff_on; // see R09
    end else begin : g_clk
      assign o_diff_obe[j] = pg11_disp; // see R12
    end
  end
  assign o_diff_out = i_timing_diff;

  assign conflict = |pad_conflict;

  // port G bit 11: enable owned by the timing controller once display is chosen
  assign pg11_disp = (pg11_r[pin_mux_pkg::PG11_OPT_LSB +: 2] == pin_mux_pkg::OPT_DISPLAY);
  assign o_pg11_out = pg11_disp ? i_panel_clock : pg11_r[pin_mux_pkg::PG11_GPIO_OUT_BIT];
  assign o_pg11_oe_n = !(pg11_disp || // see R12 see R13
                         ((pg11_r[1:0] == pin_mux_pkg::OPT_GPIO) &&
                          pg11_r[pin_mux_pkg::PG11_GPIO_OE_BIT]));
  assign o_pg11_gpio_in = (pg11_r[1:0] == pin_mux_pkg::OPT_GPIO) ? i_pg11_in : 1'b0;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  dram_strap_a: assert property ($rose(strap_done_r) |-> // see R01
    o_dram_pad_enable == $past(i_dram_bonded) && o_dram_pad_power == o_dram_pad_enable)
    else $error("memory pad enable does not follow strap");
  shared_video_a: assert property ( // see R02
    o_main_display_pixel == i_pixel_in && o_secondary_display_pixel == i_pixel_in)
    else $error("video input not shared");
  capture_write_a: assert property ( // see R03
    dp_valid_r && dp_write_r && dp_addr_r == pin_mux_pkg::MISC_CONTROL_ADDR
    |=> o_capture_pixel == ($past(i_hwdata[0]) ? i_pixel_in[17:8] :
        {i_vsync, i_hsync, i_pixel_in[7:0]}))
    else $error("capture select write not applied");
  capture_low_a: assert property (!misc_r |-> // see R04
    o_capture_pixel == {i_vsync, i_hsync, i_pixel_in[7:0]})
    else $error("capture low source wrong");
  capture_high_a: assert property (misc_r |-> o_capture_pixel == i_pixel_in[17:8]) // see R05
    else $error("capture high source wrong");
  sound_pwm_a: assert property (sound_r |-> // see R06
    o_sound_pin_clk == i_sound_pwm_out && o_sound_pin_data == i_sound_pwm_out_alt)
    else $error("pwm not on shared pins");
  sound_serial_a: assert property (!sound_r |-> // see R07
    o_sound_pin_clk == i_i2s_sck && o_sound_pin_data == i_i2s_do)
    else $error("serial audio not on shared pins");
  diff_enable_a: assert property ( // see R09
    o_diff_obe[0] == (!timing_r[0] && timing_r[1] && pad_opt_r[1:0] == 2'h1)
    && (!o_diff_obe[0] || o_pa_oe_n[0]))
    else $error("differential enable wrong");
  pg11_clock_a: assert property (pg11_r[1:0] == 2'h1 |-> // see R12
    !o_pg11_oe_n && o_diff_obe[12] && o_pg11_out == i_panel_clock)
    else $error("panel clock pad not driven");
  pa0_timer_a: assert property (pad_opt_r[1:0] == 2'h3 && i_timer_oe[0] |-> // see R14
    !o_pa_oe_n[0] && o_pa_out[0] == i_timer_out[0])
    else $error("timer option missing on pad 0");
  pa2_short_a: assert property (pad_opt_r[5:4] >= 2'h2 |-> o_pa_oe_n[2]) // see R15
    else $error("pad 2 driven on absent option");
  pa8_i2c_a: assert property (pad_opt_r[17:16] == 2'h2 |-> // see R16
    o_i2c_in[2] == i_pa_in[8] && o_pa_oe_n[8] == !i_i2c_oe[2])
    else $error("i2c option wrong on pad 8");
  select_now_a: assert property ($changed(sound_r) |-> // see R17
    o_sound_pin_clk == (sound_r ? i_sound_pwm_out : i_i2s_sck))
    else $error("selection change delayed");

  pwm_on_c: cover property ($rose(sound_r));
  capture_hi_c: cover property ($rose(misc_r));
  diff_on_c: cover property (o_diff_obe[0] && o_diff_obe[4]);
  pg11_clk_c: cover property ($fell(o_pg11_oe_n) && pg11_disp);
endmodule

/* core/pin_mux_pkg.sv */
// Overview of operation
// R01 - memory interface pads stay disabled and unpowered when that interface is not bonded
// R02 - both display units and the capture unit share one video input pin set
// R03 - bit 0 of the miscellaneous control register picks the capture pixel source
// R04 - select clear: capture takes pixel input bits 7..0 plus both syncs
// R05 - select set: capture takes pixel input bits 17..8
// R06 - sound PWM enabled: shared pins carry both PWM outputs
// R07 - sound PWM disabled: shared pins carry serial audio data and clock
// R08 - pad control slots 270..282 belong to the differential special functions
// R09 - differential pads are output only, enabled by bypass and differential mode bits
// R10 - differential pad function follows the GPIO pad option; timing controller picks style
// R11 - software keeps non-display outputs off port A and G while timing path runs
// R12 - port G bit 11 enable comes only from timing controller when display chosen
// R13 - software picks display on port G bit 11 only when ready for panel clock
// R14 - port A bit 0: GPIO, red bit 0, I2C-2 data, timer 18; diff pair 0
// R15 - port A bit 2: GPIO, red bit 2 only; diff pair 1 positive leg
// R16 - port A bit 8: GPIO, green bit 0, I2C-3 clock, timer 20; diff pair 4
// R17 - all selections are combinational, taking effect at once without frame waits
package pin_mux_pkg;
  localparam logic [31:0] MISC_CONTROL_ADDR = 32'hC3FE0340;
  localparam logic [31:0] PAD_OPTION_ADDR = 32'hC3FE0344;
  localparam logic [31:0] PAD_GPIO_ADDR = 32'hC3FE0348;
  localparam logic [31:0] PG11_CONTROL_ADDR = 32'hC3FE034C;
  localparam logic [31:0] SOUND_CONTROL_ADDR = 32'hC3FE0350;
  localparam logic [31:0] PANEL_TIMING_ONE_ADDR = 32'hC3FE0354;
  localparam logic [31:0] PAD_STATUS_ADDR = 32'hC3FE0358;

  localparam int CAPTURE_SEL_BIT = 0;
  localparam int SOUND_PWM_ENABLE_BIT = 0;
  localparam int PANEL_BYPASS_BIT = 0;
  localparam int REDUCED_SWING_MODE_BIT = 1;
  localparam int PAD_GPIO_OE_LSB = 16;
  localparam int PG11_OPT_LSB = 0;
  localparam int PG11_GPIO_OUT_BIT = 2;
  localparam int PG11_GPIO_OE_BIT = 3;
  localparam int STATUS_CONFLICT_BIT = 16;
  localparam int STATUS_DRAM_BIT = 17;
  localparam int STATUS_PG11_OE_BIT = 18;

  localparam logic [31:0] MISC_CONTROL_RST = 32'h0000_0000;
  localparam logic [31:0] PAD_OPTION_RST = 32'h0000_0000;
  localparam logic [31:0] PAD_GPIO_RST = 32'h0000_0000;
  localparam logic [3:0] PG11_CONTROL_RST = 4'h0;
  localparam logic SOUND_CONTROL_RST = 1'b0;
  localparam logic [1:0] PANEL_TIMING_ONE_RST = 2'h1;

  localparam logic [1:0] OPT_GPIO = 2'h0;
  localparam logic [1:0] OPT_DISPLAY = 2'h1;
  localparam logic [1:0] OPT_ALT2 = 2'h2;
  localparam logic [1:0] OPT_ALT3 = 2'h3;

  localparam int PA_PADS = 16;
  localparam int DIFF_SLOTS = 13;
  localparam int DIFF_SLOT_BASE = 270;
  localparam int DIFF_PA_PAIRS = 8;
endpackage

/* core/pad_mux_cell.sv */
module pad_mux_cell #(
  parameter bit HAS_ALT = 1'b0
) (
  // selection
  input wire logic [1:0] i_option,
  input wire logic i_diff_active,
  // functions
  input wire logic [3:0] i_alt_out,
  input wire logic [3:0] i_alt_oe,
  output logic [3:0] o_alt_in,
  // pad
  input wire logic i_pad_in,
  output logic o_pad_out,
  output logic o_pad_oe_n
);
  logic opt_ok;
  logic diff_owns;

  // options 2 and 3 exist only on pads that carry them
  assign opt_ok = HAS_ALT || (i_option == pin_mux_pkg::OPT_GPIO) ||
                  (i_option == pin_mux_pkg::OPT_DISPLAY);
  // the differential buffer takes the pin from the normal buffer
  assign diff_owns = i_diff_active && (i_option == pin_mux_pkg::OPT_DISPLAY); // see R10
  assign o_pad_out = opt_ok ? i_alt_out[i_option] : 1'b0; // see R17
  assign o_pad_oe_n = !(opt_ok && i_alt_oe[i_option] && !diff_owns);

  always_comb begin
    o_alt_in = 4'h0;
    if (opt_ok) begin
      o_alt_in[i_option] = i_pad_in;
    end
  end
endmodule

/* dv/pad_far_side.sv */
module pad_far_side (
  // pad drivers inside the device
  input wire logic [15:0] i_pad_out,
  input wire logic [15:0] i_pad_oe_n,
  // level that the board puts on an undriven pad
  input wire logic [15:0] i_ext_level,
  // resolved pad level
  output logic [15:0] o_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // a driven pad shows the device's data, otherwise the board level
  assign o_level = (i_pad_out & ~i_pad_oe_n) | (i_ext_level & i_pad_oe_n);
endmodule

/* dv/test_display_audio_pin_mux.sv */
module test_display_audio_pin_mux;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, bonded = 0, hs = 0, vs = 0;
  logic pw = 0, pwa = 0, sck = 0, sdo = 0, pclk = 0, pg_in = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h03FE0E2C;
  logic [17:0] pix = 18'h0;
  logic [15:0] drgb = 16'h0, trgb = 16'h0, ext = 16'h0;
  logic [12:0] tdiff = 13'h0;
  logic [3:0] i2o = 4'h0, i2e = 4'h0, tmo = 4'h0, tme = 4'h0;
  logic [31:0] hrdata, opt_m, gpio_m, pg_m, snd_m, tim_m, misc_m, st_exp;
  logic hreadyout, hresp, den, dpw, sclk, sdat, pgout, pgoen, pggin;
  logic [9:0] cap;
  logic [17:0] mpix, spix;
  logic [3:0] i2in, tmin;
  logic [15:0] gin, paout, paoen, pain;
  logic [12:0] dout, dobe;
  int n_errors = 0, compares = 0, cycles = 0;

  display_audio_pin_mux display_audio_pin_mux_i (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
    .o_hresp(hresp), .i_dram_bonded(bonded), .o_dram_pad_enable(den),
    .o_dram_pad_power(dpw), .i_pixel_in(pix), .i_hsync(hs), .i_vsync(vs),
    .o_capture_pixel(cap), .o_main_display_pixel(mpix), .o_secondary_display_pixel(spix),
    .i_sound_pwm_out(pw), .i_sound_pwm_out_alt(pwa), .i_i2s_sck(sck), .i_i2s_do(sdo),
    .o_sound_pin_clk(sclk), .o_sound_pin_data(sdat), .i_display_rgb(drgb),
    .i_timing_rgb(trgb), .i_timing_diff(tdiff), .i_panel_clock(pclk), .i_i2c_out(i2o),
    .i_i2c_oe(i2e), .o_i2c_in(i2in), .i_timer_out(tmo), .i_timer_oe(tme),
    .o_timer_in(tmin), .o_gpio_in(gin), .i_pa_in(pain), .o_pa_out(paout),
    .o_pa_oe_n(paoen), .i_pg11_in(pg_in), .o_pg11_out(pgout), .o_pg11_oe_n(pgoen),
    .o_pg11_gpio_in(pggin), .o_diff_out(dout), .o_diff_obe(dobe));

  pad_far_side pad_far_side_i (.i_pad_out(paout), .i_pad_oe_n(paoen), .i_ext_level(ext),
    .o_level(pain));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic tally_and_finish();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic bus(input bit wr, input logic [31:0] a, d, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic w(input logic [31:0] a, d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rchk(input string n, input logic [31:0] a, e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(n, e, x);
    chk("hready", 32'h1, hreadyout);
    chk("hresp", 32'h0, hresp);
  endtask

  // new random levels on every pin-side input except the package strap
  task automatic shake();
    logic [31:0] r;
    @(posedge clk);
    r = rnd();
    pix <= r[17:0];
    {hs, vs, pw, pwa, sck, sdo, pclk, pg_in} <= r[25:18];
    r = rnd();
    {drgb, trgb} <= r;
    r = rnd();
    {ext, tdiff} <= r[28:0];
    r = rnd();
    {i2o, i2e, tmo, tme} <= r[15:0];
    #1;
  endtask

  task automatic pins();
    logic [12:0] e;
    logic [1:0] o;
    logic oen, lv, don, cf;
    int x;
    don = !tim_m[0] && tim_m[1];
    cf = 1'b0;
    for (int j = 0; j < 8; j++) e[j] = don && opt_m[4*j +: 2] == 2'h1;
    e[11:8] = {4{don}};
    e[12] = pg_m[1:0] == 2'h1;
    chk("diff_obe", e, dobe);
    chk("diff_out", tdiff, dout);
    chk("capture", misc_m[0] ? pix[17:8] : {vs, hs, pix[7:0]}, cap);
    chk("main_pix", pix, mpix);
    chk("sec_pix", pix, spix);
    chk("snd_clk", snd_m[0] ? pw : sck, sclk);
    chk("snd_data", snd_m[0] ? pwa : sdo, sdat);
    for (int p = 0; p < 16; p++) begin
      o = opt_m[2*p +: 2];
      x = p == 0 ? 0 : p == 1 ? 1 : p == 8 ? 2 : p == 9 ? 3 : -1;
      oen = 1'b1;
      lv = 1'b0;
      if (o == 2'h0) begin
        oen = ~gpio_m[16+p];
        lv = gpio_m[p];
      end else if (o == 2'h1) begin
        // the differential buffer takes every display pad while it runs
        oen = don;
        lv = tim_m[0] ? drgb[p] : trgb[p];
      end else if (x >= 0) begin
        oen = o == 2'h2 ? ~i2e[x] : ~tme[x];
        lv = o == 2'h2 ? i2o[x] : tmo[x];
      end
      cf |= !tim_m[0] && !oen && o != 2'h1;
      chk("pa_oe_n", oen, paoen[p]);
      if (!oen) chk("pa_out", lv, paout[p]);
      chk("gpio_in", o == 2'h0 ? (oen ? ext[p] : lv) : 1'b0, gin[p]);
      if (x >= 0) begin
        chk("i2c_in", o == 2'h2 ? (oen ? ext[p] : lv) : 1'b0, i2in[x]);
        chk("timer_in", o == 2'h3 ? (oen ? ext[p] : lv) : 1'b0, tmin[x]);
      end
    end
    o = pg_m[1:0];
    oen = o == 2'h1 ? 1'b0 : o == 2'h0 ? ~pg_m[3] : 1'b1;
    chk("pg11_oe_n", oen, pgoen);
    if (!oen) chk("pg11_out", o == 2'h1 ? pclk : pg_m[2], pgout);
    chk("pg11_gpio_in", o == 2'h0 ? pg_in : 1'b0, pggin);
    st_exp = {13'h0, !oen, 1'b1, cf, 3'h0, e};
  endtask

  initial begin
    for (int r = 0; r < 2; r++) begin
      if (r > 0) @(posedge clk);
      rst_n <= 1'b0;
      bonded <= r[0];
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // the strap is latched: later changes must not reach the pads
      bonded <= 1'b0;
      #1;
      chk("dram_enable", r, den);
      chk("dram_power", r, dpw);
    end
    {misc_m, opt_m, gpio_m, pg_m, snd_m} = '0;
    tim_m = 32'h1;
    rchk("misc_rst", pin_mux_pkg::MISC_CONTROL_ADDR, 32'h0);
    rchk("timing_rst", pin_mux_pkg::PANEL_TIMING_ONE_ADDR, 32'h1);
    rchk("unmapped", 32'hC3FE0400, 32'h0);
    shake();
    pins();
    // conflicting setups are made on purpose so the status flag is exercised
    for (int i = 0; i < 40; i++) begin
      misc_m = rnd() & 32'h1;
      w(pin_mux_pkg::MISC_CONTROL_ADDR, misc_m);
      snd_m = rnd() & 32'h1;
      w(pin_mux_pkg::SOUND_CONTROL_ADDR, snd_m);
      opt_m = rnd();
      w(pin_mux_pkg::PAD_OPTION_ADDR, opt_m);
      gpio_m = rnd();
      w(pin_mux_pkg::PAD_GPIO_ADDR, gpio_m);
      pg_m = rnd() & 32'hF;
      w(pin_mux_pkg::PG11_CONTROL_ADDR, pg_m);
      tim_m = rnd() & 32'h3;
      w(pin_mux_pkg::PANEL_TIMING_ONE_ADDR, tim_m);
      w(pin_mux_pkg::PAD_STATUS_ADDR, rnd());
      #1;
      pins();
      shake();
      pins();
      rchk("status", pin_mux_pkg::PAD_STATUS_ADDR, st_exp);
      rchk("option", pin_mux_pkg::PAD_OPTION_ADDR, opt_m);
      rchk("misc", pin_mux_pkg::MISC_CONTROL_ADDR, misc_m);
    end
    tally_and_finish();
  end
endmodule
